// ===== rtl/pcct_pkg.sv
// pcct_pkg: register map, field positions and reset values of the pwm/capture timer
// assumes a 32-bit avalon-mm slave with word addresses (byte address = 4 * index)
package pcct_pkg;

	localparam int ADDR_W = 4;

	// register indices (word address on the bus)
	localparam logic [3:0] IDX_CNT_HI  = 4'h0;
	localparam logic [3:0] IDX_CNT_LO  = 4'h1;
	localparam logic [3:0] IDX_RLD_HI  = 4'h2;
	localparam logic [3:0] IDX_RLD_LO  = 4'h3;
	localparam logic [3:0] IDX_PWM_HI  = 4'h4;
	localparam logic [3:0] IDX_PWM_LO  = 4'h5;
	localparam logic [3:0] IDX_CTL0    = 4'h6;
	localparam logic [3:0] IDX_CTL1    = 4'h7;
	localparam logic [3:0] IDX_IRQ_ST  = 4'h8;
	localparam logic [3:0] IDX_IRQ_EN  = 4'h9;
	localparam logic [3:0] IDX_IRQ_CLR = 4'hA;

	// control 0 fields
	localparam int CTL0_EN_BIT   = 7;
	localparam int CTL0_POL_BIT  = 6;
	localparam int CTL0_MODE_BIT = 0;

	// control 1 fields
	localparam int CTL1_CAP_BIT  = 0;
	localparam int CTL1_SRC_LSB  = 1;

	// irq status bits
	localparam int ST_RELOAD_BIT = 0;
	localparam int ST_CAPT_BIT   = 1;

	// reset values, and the count loaded at each restart
	localparam logic [15:0] CNT_RST     = 16'h0000;
	localparam logic [15:0] RLD_RST     = 16'hFFFF;
	localparam logic [15:0] PWM_RST     = 16'h0000;
	localparam logic [15:0] RESTART_CNT = 16'h0001;

	typedef enum logic [1:0] {
		PCCT_SRC_BOTH    = 2'b00,
		PCCT_SRC_BOTH2   = 2'b01,
		PCCT_SRC_CAPTURE = 2'b10,
		PCCT_SRC_RELOAD  = 2'b11
	} pcct_src_t;

endpackage

// ===== rtl/pcct_edge_sync.sv
// pcct_edge_sync: two-flop synchroniser of the timer input pin plus edge detection
// assumes the pin is asynchronous to mclk
module pcct_edge_sync (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic pin,
	input  wire logic rise_sel,
	output logic      edge_seen,
	output logic      level
);
	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
		end
	end

	// edge is judged on the second flop and its delayed copy only
	assign edge_seen = rise_sel ? (sync & ~prev) : (~sync & prev);
	assign level     = sync;
endmodule

// ===== rtl/pcct_timer.sv
// pcct_timer: 16-bit timer with single-output pwm and capture/compare modes
// assumes an avalon-mm master on mclk and an asynchronous timer input pin
// Summary of operation
// - pwm counts clock, toggles output at match
// - pwm reload value: interrupt, restart at 0001
// - polarity one: start high, low at match
// - polarity zero: start low, high at match
// - written start count only for first pass
// - capture mode starts on first selected edge
// - later edge captures count, interrupts, restarts
// - capture sets capture cause flag
// - compare reached: interrupt, restart, clear flag
// - irq source select: both, capture, reload
module pcct_timer (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        timer_in,
	output logic             timer_out,
	output logic             irq
);
	logic [15:0] count;
	logic [15:0] reload;
	logic [15:0] pwm;
	logic        enable;
	logic        polarity;
	logic        mode_capture;
	logic [1:0]  src_sel;
	logic        cap_flag;
	logic        armed;
	logic [1:0]  irq_status;
	logic [1:0]  irq_enable;
	logic        rd_done;
	logic        out_q;

	logic        in_edge;
	logic        wr_fire;
	logic        rd_fire;
	logic [7:0]  wbyte;
	logic        hit_match;
	logic        hit_reload;
	logic        capture_ev;
	logic        reload_ev;
	logic        irq_rld_ok;
	logic        irq_cap_ok;
	logic [1:0]  next_status;

	pcct_edge_sync u_sync (
		.mclk      (mclk),
		.rstn      (rstn),
		.pin       (timer_in),
		.rise_sel  (polarity),
		.edge_seen (in_edge),
		.level     ()
	);

	// writes take effect at once; reads wait one cycle so readdata comes from a flop
	assign wr_fire         = avs_write;
	assign rd_fire         = avs_read & rd_done;
	assign avs_waitrequest = avs_read & ~rd_done;
	assign wbyte           = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

	function automatic logic wr_to(input logic [3:0] idx);
		wr_to = avs_write & avs_byteenable[0] & (avs_address == idx);
	endfunction

	// events: none while disabled, and capture mode waits for its first edge
	assign hit_match  = enable & ~mode_capture & (count == pwm);
	assign hit_reload = enable & (count == reload) & (~mode_capture | armed);
	assign capture_ev = enable & mode_capture & armed & in_edge;
	assign reload_ev  = hit_reload & ~capture_ev;

	// source select gates which events may raise the interrupt
	assign irq_cap_ok = (src_sel != pcct_pkg::PCCT_SRC_RELOAD);
	assign irq_rld_ok = (src_sel != pcct_pkg::PCCT_SRC_CAPTURE);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_done <= 1'b0;
		end else begin
			rd_done <= avs_read & ~rd_done;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~rd_done) begin
			case (avs_address)
				pcct_pkg::IDX_CNT_HI:  avs_readdata <= {24'h00_0000, count[15:8]};
				pcct_pkg::IDX_CNT_LO:  avs_readdata <= {24'h00_0000, count[7:0]};
				pcct_pkg::IDX_RLD_HI:  avs_readdata <= {24'h00_0000, reload[15:8]};
				pcct_pkg::IDX_RLD_LO:  avs_readdata <= {24'h00_0000, reload[7:0]};
				pcct_pkg::IDX_PWM_HI:  avs_readdata <= {24'h00_0000, pwm[15:8]};
				pcct_pkg::IDX_PWM_LO:  avs_readdata <= {24'h00_0000, pwm[7:0]};
				pcct_pkg::IDX_CTL0:    avs_readdata <= {24'h00_0000, enable, polarity, 5'b0_0000, mode_capture};
				pcct_pkg::IDX_CTL1:    avs_readdata <= {24'h00_0000, 5'b0_0000, src_sel, cap_flag};
				pcct_pkg::IDX_IRQ_ST:  avs_readdata <= {30'h0000_0000, irq_status};
				pcct_pkg::IDX_IRQ_EN:  avs_readdata <= {30'h0000_0000, irq_enable};
				default:               avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// control registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			enable       <= 1'b0;
			polarity     <= 1'b0;
			mode_capture <= 1'b0;
		end else if (wr_to(pcct_pkg::IDX_CTL0)) begin
			enable       <= wbyte[pcct_pkg::CTL0_EN_BIT];
			polarity     <= wbyte[pcct_pkg::CTL0_POL_BIT];
			mode_capture <= wbyte[pcct_pkg::CTL0_MODE_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			src_sel <= 2'b00;
		end else if (wr_to(pcct_pkg::IDX_CTL1)) begin
			src_sel <= wbyte[pcct_pkg::CTL1_SRC_LSB +: 2];
		end
	end

	// capture cause flag: set by capture, cleared by compare reload
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cap_flag <= 1'b0;
		end else if (capture_ev) begin
			cap_flag <= 1'b1;
		end else if (reload_ev & mode_capture) begin
			cap_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reload <= pcct_pkg::RLD_RST;
		end else if (wr_to(pcct_pkg::IDX_RLD_HI)) begin
			reload[15:8] <= wbyte;
		end else if (wr_to(pcct_pkg::IDX_RLD_LO)) begin
			reload[7:0] <= wbyte;
		end
	end

	// pwm register doubles as the capture register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pwm <= pcct_pkg::PWM_RST;
		end else if (capture_ev) begin
			pwm <= count;
		end else if (wr_to(pcct_pkg::IDX_PWM_HI)) begin
			pwm[15:8] <= wbyte;
		end else if (wr_to(pcct_pkg::IDX_PWM_LO)) begin
			pwm[7:0] <= wbyte;
		end
	end

	// capture mode arms on the first selected edge; disabling disarms
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			armed <= 1'b0;
		end else if (!enable || !mode_capture) begin
			armed <= 1'b0;
		end else if (in_edge) begin
			armed <= 1'b1;
		end
	end

	// counter: software-written start only counts for the first pass
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count <= pcct_pkg::CNT_RST;
		end else if (wr_to(pcct_pkg::IDX_CNT_HI)) begin
			count[15:8] <= wbyte;
		end else if (wr_to(pcct_pkg::IDX_CNT_LO)) begin
			count[7:0] <= wbyte;
		end else if (capture_ev || reload_ev) begin
			count <= pcct_pkg::RESTART_CNT;
		end else if (enable && (!mode_capture || armed)) begin
			count <= count + 16'h0001;
		end
	end

	// output pin: rests at the polarity level whenever the timer is off
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			out_q <= 1'b0;
		end else if (!enable || mode_capture) begin
			out_q <= polarity;
		end else if (reload_ev) begin
			out_q <= polarity;
		end else if (hit_match) begin
			out_q <= ~out_q;
		end
	end
	assign timer_out = out_q;

	// sticky status: set wins over a clear in the same cycle
	always_comb begin
		next_status = irq_status;
		if (wr_to(pcct_pkg::IDX_IRQ_CLR)) begin
			next_status = irq_status & ~wbyte[1:0];
		end
		if (reload_ev && irq_rld_ok) begin
			next_status[pcct_pkg::ST_RELOAD_BIT] = 1'b1;
		end
		if (capture_ev && irq_cap_ok) begin
			next_status[pcct_pkg::ST_CAPT_BIT] = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_status <= 2'b00;
		end else begin
			irq_status <= next_status;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_enable <= 2'b00;
		end else if (wr_to(pcct_pkg::IDX_IRQ_EN)) begin
			irq_enable <= wbyte[1:0];
		end
	end

	assign irq = |(irq_status & irq_enable);

endmodule

// ===== testbench/pcct_properties.sv
// pcct_properties: port-level checks of pcct_timer
// assumes it is bound to pcct_timer and shadows the control writes it sees on the bus
module pcct_properties (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        timer_in,
	input wire logic        timer_out,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       en, pol, cap, wr;
	logic [1:0] src, ien, age;
	logic [7:0] rld [2];
	assign wr = avs_write && avs_byteenable[0];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// age counts cycles since the last control 0 write, so checks skip the settling cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{en, pol, cap, src, ien, age} <= 9'h003;
			rld <= '{8'hFF, 8'hFF};
		end else begin
			age <= (age == 2'h3) ? age : age + 2'h1;
			if (wr && avs_address == 4'h6) begin
				{en, pol} <= avs_writedata[7:6];
				cap <= avs_writedata[0];
				age <= 2'h0;
			end
			if (wr && avs_address == 4'h7)
				src <= avs_writedata[2:1];
			if (wr && avs_address == 4'h9)
				ien <= avs_writedata[1:0];
			if (wr && avs_address[3:1] == 3'h1)
				rld[avs_address[0]] <= avs_writedata[7:0];
		end
	end
	AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest)
		else $error("read not held first cycle");
	AST_RD_ONE: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read answer late");
	AST_RD_HOLD: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data moved");
	AST_RLD_BACK: assert property (avs_read && !avs_waitrequest && avs_address[3:1] == 3'h1 |->
		avs_readdata == {24'h00_0000, rld[avs_address[0]]}) else $error("reload readback wrong");
	AST_OUT_IDLE: assert property ((!en || cap) && age > 2'h1 |-> timer_out == pol)
		else $error("idle output not at polarity");
	AST_PWM_RLD: assert property (en && !cap && age > 2'h1 && timer_out != $past(timer_out)
		&& timer_out == pol && ien[0] && src != 2'h2 |-> irq) else $error("no irq at reload");
	AST_IRQ_MASK: assert property (irq |-> ien != 2'h0)
		else $error("irq while masked");
	AST_DIS_QUIET: assert property (!en && age > 2'h1 && !avs_write |=> !$rose(irq))
		else $error("event while disabled");
	COV_PWM: cover property (en && !cap && irq);
	COV_CAP: cover property (en && cap && irq);
	COV_DIS: cover property (!en && age == 2'h3 && timer_out);
endmodule

// ===== testbench/pcct_pin_model.sv
// pcct_pin_model: external circuit on the timer pins
// assumes strike is called right after a rising edge of mclk
module pcct_pin_model (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic timer_out,
	output logic      timer_in,
	output int        hi_len,
	output int        lo_len
);
	timeunit 1ns;
	timeprecision 1ps;
	int   run;
	logic prev;
	initial timer_in = 1'b0;
	// a phase is reported only once it ends; a stuck output leaves the old figure
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			run <= 1;
			prev <= 1'b0;
		end else if (timer_out !== prev) begin
			if (prev)
				hi_len <= run;
			else
				lo_len <= run;
			run <= 1;
			prev <= timer_out;
		end else
			run <= run + 1;
	end
	// one rising edge, then gap cycles until the next may come
	task automatic strike(input int gap);
		timer_in <= 1'b1;
		repeat (gap / 2) @(posedge mclk);
		timer_in <= 1'b0;
		repeat (gap - gap / 2) @(posedge mclk);
	endtask
endmodule

// ===== testbench/pcct_timer_tb.sv
// pcct_timer_tb: directed tests of the pwm/capture timer through its avalon-mm port
// assumes pcct_pin_model as the far side of the timer pins
module pcct_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, timer_in, timer_out, irq;
	logic [7:0]  q, q2;
	int          hi_len, lo_len;
	int          fails = 0;
	int          cmp_count = 0;
	always #4 mclk = ~mclk;
	pcct_timer DUT (.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_in(timer_in),
		.timer_out(timer_out), .irq(irq));
	pcct_pin_model pin (.mclk(mclk), .rstn(rstn), .timer_out(timer_out), .timer_in(timer_in),
		.hi_len(hi_len), .lo_len(lo_len));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one bus cycle; a read leaves its data in q
	// no cycle count is assumed: a slave that never answers is ended by the watchdog
	task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h00_0000, d};
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic test_regs;
		logic [7:0] rv [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			bus(4'(i), 1'b0, 8'h00);
			check("reset value", q, rv[i]);
		end
		bus(4'h3, 1'b1, 8'h5A);
		avs_byteenable <= 4'h0;
		bus(4'h3, 1'b1, 8'h00);
		avs_byteenable <= 4'hF;
		bus(4'h3, 1'b0, 8'h00);
		check("reload low", q, 8'h5A);
		bus(4'hB, 1'b0, 8'h00);
		check("unmapped", q, 8'h00);
		$display("register test done");
	endtask
	// start count 8 misses the first match, so later passes must restart at 1
	task automatic test_pwm(input logic pol);
		bus(4'h6, 1'b1, {1'b0, pol, 6'h00});
		bus(4'h0, 1'b1, 8'h00);
		bus(4'h1, 1'b1, 8'h08);
		bus(4'h4, 1'b1, 8'h00);
		bus(4'h5, 1'b1, 8'h06);
		bus(4'h2, 1'b1, 8'h00);
		bus(4'h3, 1'b1, 8'h0A);
		bus(4'h9, 1'b1, 8'h01);
		bus(4'h6, 1'b1, {1'b1, pol, 6'h00});
		repeat (60) @(posedge mclk);
		check("start level phase", 16'(pol ? hi_len : lo_len), 16'h0006);
		check("toggled phase", 16'(pol ? lo_len : hi_len), 16'h0004);
		check("reload irq", irq, 1'b1);
		bus(4'h6, 1'b1, {1'b0, pol, 6'h00});
		bus(4'hA, 1'b1, 8'h03);
		bus(4'h1, 1'b0, 8'h00);
		q2 = q;
		repeat (30) @(posedge mclk);
		bus(4'h1, 1'b0, 8'h00);
		check("held count", q, q2);
		check("quiet irq", irq, 1'b0);
		$display("pwm test done");
	endtask
	task automatic test_cap;
		bus(4'h6, 1'b1, 8'h41);
		bus(4'h1, 1'b1, 8'h01);
		bus(4'h3, 1'b1, 8'hC8);
		bus(4'h9, 1'b1, 8'h02);
		bus(4'h7, 1'b1, 8'h02);
		bus(4'h6, 1'b1, 8'hC1);
		repeat (20) @(posedge mclk);
		bus(4'h1, 1'b0, 8'h00);
		check("unarmed count", q, 8'h01);
		repeat (3) pin.strike(30);
		bus(4'h5, 1'b0, 8'h00);
		check("captured count", q, 8'h1E);
		bus(4'h7, 1'b0, 8'h00);
		check("capture cause", q[0], 1'b1);
		check("capture irq", irq, 1'b1);
		bus(4'h7, 1'b1, 8'h04);
		bus(4'hA, 1'b1, 8'h03);
		bus(4'h9, 1'b1, 8'h03);
		repeat (220) @(posedge mclk);
		bus(4'h7, 1'b0, 8'h00);
		check("compare cause", q[0], 1'b0);
		check("capture-only irq", irq, 1'b0);
		bus(4'h7, 1'b1, 8'h06);
		repeat (220) @(posedge mclk);
		check("reload-only irq", irq, 1'b1);
		bus(4'h6, 1'b1, 8'h41);
		$display("capture test done");
	endtask
	// falling-edge capture: the pin idles low, so the first fall arms mid-strike
	task automatic test_fall;
		bus(4'h6, 1'b1, 8'h01);
		bus(4'h1, 1'b1, 8'h01);
		bus(4'h7, 1'b1, 8'h00);
		bus(4'hA, 1'b1, 8'h03);
		bus(4'h6, 1'b1, 8'h81);
		repeat (3) pin.strike(30);
		bus(4'h5, 1'b0, 8'h00);
		check("falling capture", q, 8'h1E);
		bus(4'h8, 1'b0, 8'h00);
		check("capture status", q, 8'h02);
		bus(4'h9, 1'b0, 8'h00);
		check("irq enable", q, 8'h03);
		bus(4'h6, 1'b1, 8'h01);
		$display("falling capture test done");
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		test_regs();
		test_pwm(1'b0);
		test_pwm(1'b1);
		test_cap();
		test_fall();
		tally_and_finish();
	end
	initial begin
		#100us;
		fails++;
		tally_and_finish();
	end
endmodule
bind pcct_timer pcct_properties u_props (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.timer_in(timer_in), .timer_out(timer_out), .irq(irq));
